// ==== pkg/smb_status_pkg.sv ====
// package for the two-wire slave status coder
package smb_status_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses on apb)
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_ADDR    = 8'h00;
	localparam logic [7:0] STATUS_ADDR  = 8'h04;
	localparam logic [7:0] DATA_ADDR    = 8'h08;
	localparam logic [7:0] RATE_ADDR    = 8'h0C;
	localparam logic [7:0] OWNADDR_ADDR = 8'h10;
	// control register fields
	localparam int CTRL_EVENT_BIT = 3;
	localparam int CTRL_ACK_BIT   = 2;
	localparam int CTRL_STOP_BIT  = 4;
	localparam int CTRL_ENA_BIT   = 6;
	localparam int CTRL_GC_BIT    = 0;
	localparam int CTRL_LOST_BIT  = 1;
	// reset values
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [7:0] DATA_RESET    = 8'h00;
	localparam logic [7:0] RATE_RESET    = 8'h00;
	localparam logic [6:0] OWNADDR_RESET = 7'h00;
	// status codes
	localparam logic [7:0] ST_OWN_W      = 8'h60;
	localparam logic [7:0] ST_LOST_OWN_W = 8'h68;
	localparam logic [7:0] ST_GC         = 8'h70;
	localparam logic [7:0] ST_LOST_GC    = 8'h78;
	localparam logic [7:0] ST_RX_ACK     = 8'h80;
	localparam logic [7:0] ST_RX_NACK    = 8'h88;
	localparam logic [7:0] ST_GC_ACK     = 8'h90;
	localparam logic [7:0] ST_GC_NACK    = 8'h98;
	localparam logic [7:0] ST_STOP       = 8'hA0;
	localparam logic [7:0] ST_OWN_R      = 8'hA8;
	localparam logic [7:0] ST_LOST_OWN_R = 8'hB0;
	localparam logic [7:0] ST_TX_ACK     = 8'hB8;
	localparam logic [7:0] ST_TX_NACK    = 8'hC0;
	localparam logic [7:0] ST_TX_LAST    = 8'hC8;
	localparam logic [7:0] ST_TIMEOUT    = 8'hD0;
	localparam logic [7:0] ST_BUS_ERR    = 8'h00;
	localparam logic [7:0] ST_IDLE       = 8'hF8;
	// ------------------------------------------------------------
	// timing: scl-high timeout is (256 - rate) * 8 system clocks
	// ------------------------------------------------------------
	localparam int TIMEOUT_UNIT = 8;

	typedef enum logic [5:0]
	{
		S_IDLE = 6'b000001,
		S_ADDR = 6'b000010,
		S_RX   = 6'b000100,
		S_TX   = 6'b001000,
		S_HOLD = 6'b010000,
		S_WAIT = 6'b100000
	} slave_state_type;

	typedef struct packed
	{
		logic scl;
		logic sda;
	} bus_pins_type;
endpackage

// ==== rtl/smb_status_coder.sv ====
// two-wire slave engine with status coder and apb registers
//------------------------------------------------------------
// How it works
// - own address write acked gives 60
// - lost arbitration then own write gives 68
// - general call acked gives 70
// - lost arbitration then general call gives 78
// - slave data byte acked gives 80
// - slave data byte nacked gives 88
// - general call data gives 90 or 98
// - stop or repeated start gives A0 in the receive or wait state, but not in the address or transmit state
// - own address read acked gives A8
// - lost arbitration then own read gives B0
// - transmitted byte acked B8, nacked C0
// - last byte still acked gives C8
// - scl high timer expiry gives D0
// - illegal start or stop gives 00
// - idle shows F8, no event flag
// - low three status bits zero when flagged
//------------------------------------------------------------
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module smb_status_coder
	import smb_status_pkg::*;
(
	input  wire logic        clk_in,      // 50 mhz system clock
	input  wire logic        rst_in,      // async reset, active high
	input  wire logic        psel_in,     // apb select
	input  wire logic        penable_in,  // apb enable
	input  wire logic        pwrite_in,   // apb direction
	input  wire logic [7:0]  paddr_in,    // apb byte address
	input  wire logic [31:0] pwdata_in,   // apb write data
	output logic      [31:0] prdata_out,  // apb read data
	output logic             pready_out,  // apb ready
	output logic             pslverr_out, // apb error
	input  wire logic        scl_in,      // scl pin level
	input  wire logic        sda_in,      // sda pin level
	output logic             sda_oe_n_out // low pulls sda low
);
	//------------------------------------------------------------
	// pin synchronisers and edge detect
	//------------------------------------------------------------
	bus_pins_type meta_r, sync_r, prev_r;
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			{meta_r, sync_r, prev_r} <= 6'h3F;
		else
		begin
			meta_r <= '{scl: scl_in, sda: sda_in};
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end
	wire scl_rise = sync_r.scl & ~prev_r.scl;
	wire scl_fall = ~sync_r.scl & prev_r.scl;
	wire start_c  = prev_r.scl & sync_r.scl & prev_r.sda & ~sync_r.sda;
	wire stop_c   = prev_r.scl & sync_r.scl & ~prev_r.sda & sync_r.sda;

	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	logic [7:0]      ctrl_r, data_r, rate_r, status_r, shift_r;
	logic [6:0]      own_r;
	logic [3:0]      bit_r;
	logic            gc_r, ack_phase_r, ack_out_r, last_r, lost_r;
	slave_state_type state_r;
	logic [11:0]     tmo_r;
	wire event_r   = ctrl_r[CTRL_EVENT_BIT];
	wire enabled   = ctrl_r[CTRL_ENA_BIT];
	wire apb_wr    = psel_in & penable_in & pwrite_in;
	wire mapped    = paddr_in inside {CTRL_ADDR, STATUS_ADDR, DATA_ADDR, RATE_ADDR, OWNADDR_ADDR};
	// event: a new status code and the event flag are raised together
	logic       ev;
	logic [7:0] ev_code;
	wire        in_frame = state_r != S_IDLE;
	wire        tmo_hit  = in_frame && tmo_r == 12'h000 && sync_r.scl && sync_r.sda;
	always_comb
	begin
		ev      = 1'b0;
		ev_code = ST_IDLE;
		if (tmo_hit)
		begin
			ev      = 1'b1;
			ev_code = ST_TIMEOUT;
		end
		else if ((start_c || stop_c) && (state_r == S_RX || state_r == S_TX) && bit_r > 4'd1)
		begin
			ev      = 1'b1;
			ev_code = ST_BUS_ERR;
		end
		else if ((start_c || stop_c) && (state_r == S_RX || state_r == S_HOLD || state_r == S_WAIT))
		begin
			ev      = 1'b1;
			ev_code = ST_STOP;
		end
		else if (scl_fall && ack_phase_r && state_r == S_ADDR && ack_out_r)
		begin
			ev = 1'b1;
			if (gc_r)
				ev_code = lost_r ? ST_LOST_GC : ST_GC;
			else if (shift_r[0])
				ev_code = lost_r ? ST_LOST_OWN_R : ST_OWN_R;
			else
				ev_code = lost_r ? ST_LOST_OWN_W : ST_OWN_W;
		end
		else if (scl_fall && ack_phase_r && state_r == S_RX)
		begin
			ev = 1'b1;
			if (gc_r)
				ev_code = ack_out_r ? ST_GC_ACK : ST_GC_NACK;
			else
				ev_code = ack_out_r ? ST_RX_ACK : ST_RX_NACK;
		end
		else if (scl_rise && ack_phase_r && state_r == S_TX)
		begin
			ev = 1'b1;
			if (sync_r.sda)
				ev_code = ST_TX_NACK;
			else
				ev_code = last_r ? ST_TX_LAST : ST_TX_ACK;
		end
	end

	//------------------------------------------------------------
	// apb slave: one access cycle, zero wait states
	//------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			{prdata_out, pready_out, pslverr_out} <= 34'h0;
		else
		begin
			pready_out  <= psel_in & ~penable_in;
			pslverr_out <= psel_in & ~penable_in & ~mapped;
			if (psel_in && !penable_in && !pwrite_in)
				unique case (paddr_in)
					CTRL_ADDR:    prdata_out <= {24'h000000, ctrl_r};
					STATUS_ADDR:  prdata_out <= {24'h000000, status_r};
					DATA_ADDR:    prdata_out <= {24'h000000, data_r};
					RATE_ADDR:    prdata_out <= {24'h000000, rate_r};
					OWNADDR_ADDR: prdata_out <= {25'h0000000, own_r};
					default:      prdata_out <= 32'h0000_0000;
				endcase
		end
	end
	wire acc   = pready_out & psel_in & penable_in;
	wire wr_ct = acc & apb_wr & paddr_in == CTRL_ADDR;

	// control: event flag set by hardware wins over software clear
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			ctrl_r <= CTRL_RESET;
		else
		begin
			if (wr_ct)
				ctrl_r <= pwdata_in[7:0];
			if (ev)
				ctrl_r[CTRL_EVENT_BIT] <= 1'b1;
			else if (state_r == S_IDLE && !wr_ct)
				ctrl_r[CTRL_STOP_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			status_r <= ST_IDLE;
		else if (ev)
			status_r <= {ev_code[7:3], 3'b000};
		else if (!event_r || (wr_ct && !pwdata_in[CTRL_EVENT_BIT]))
			status_r <= ST_IDLE;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rate_r <= RATE_RESET;
			own_r  <= OWNADDR_RESET;
		end
		else if (acc && apb_wr)
		begin
			if (paddr_in == RATE_ADDR)
				rate_r <= pwdata_in[7:0];
			if (paddr_in == OWNADDR_ADDR)
				own_r <= pwdata_in[6:0];
		end
	end

	// scl-high timer reloads on every scl low
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			tmo_r <= 12'hFFF;
		else if (!sync_r.scl || !in_frame)
			tmo_r <= 12'((12'h100 - {4'h0, rate_r}) * TIMEOUT_UNIT);
		else if (tmo_r != 12'h000)
			tmo_r <= tmo_r - 12'd1;
	end

	//------------------------------------------------------------
	// bit engine
	//------------------------------------------------------------
	wire addr_match = shift_r[7:1] == own_r;
	wire gc_match   = shift_r == 8'h00 && ctrl_r[CTRL_GC_BIT];
	wire ack_now    = (state_r != S_ADDR || addr_match || gc_match) && ctrl_r[CTRL_ACK_BIT];
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_r      <= S_IDLE;
			shift_r      <= 8'h00;
			bit_r        <= 4'd0;
			gc_r         <= 1'b0;
			ack_phase_r  <= 1'b0;
			ack_out_r    <= 1'b0;
			last_r       <= 1'b0;
			lost_r       <= 1'b0;
			data_r       <= DATA_RESET;
			sda_oe_n_out <= 1'b1;
		end
		else
		begin
			if (acc && apb_wr && paddr_in == DATA_ADDR)
				data_r <= pwdata_in[7:0];
			if (!enabled || ctrl_r[CTRL_STOP_BIT] || tmo_hit || stop_c)
			begin
				state_r      <= S_IDLE;
				sda_oe_n_out <= 1'b1;
				bit_r        <= 4'd0;
				ack_phase_r  <= 1'b0;
			end
			else if (start_c)
			begin
				state_r      <= (ev && ev_code == ST_BUS_ERR) ? S_IDLE : S_ADDR;
				lost_r       <= ctrl_r[CTRL_LOST_BIT];
				bit_r        <= 4'd0;
				ack_phase_r  <= 1'b0;
				gc_r         <= 1'b0;
				sda_oe_n_out <= 1'b1;
			end
			else if (state_r != S_IDLE && state_r != S_HOLD && state_r != S_WAIT)
			begin
				if (scl_rise && !ack_phase_r && state_r != S_TX)
				begin
					shift_r <= {shift_r[6:0], sync_r.sda};
					bit_r   <= bit_r + 4'd1;
				end
				if (scl_fall && !ack_phase_r && bit_r == 4'd8 && state_r != S_TX)
				begin
					ack_phase_r  <= 1'b1;
					ack_out_r    <= ack_now;
					gc_r         <= state_r == S_ADDR ? gc_match : gc_r;
					sda_oe_n_out <= ~ack_now;
					if (state_r == S_RX)
						data_r <= shift_r;
				end
				else if (scl_fall && ack_phase_r && state_r != S_TX)
				begin
					ack_phase_r  <= 1'b0;
					bit_r        <= 4'd0;
					sda_oe_n_out <= 1'b1;
					if (!ack_out_r)
						state_r <= state_r == S_ADDR ? S_IDLE : S_WAIT;
					else if (state_r == S_ADDR && shift_r[0] && !gc_r)
					begin
						state_r      <= S_TX;
						shift_r      <= data_r;
						sda_oe_n_out <= data_r[7];
						bit_r        <= 4'd1;
					end
					else
						state_r <= S_RX;
				end
				else if (state_r == S_TX && scl_fall && !ack_phase_r)
				begin
					if (bit_r == 4'd8)
					begin
						ack_phase_r  <= 1'b1;
						sda_oe_n_out <= 1'b1;
						last_r       <= ~ctrl_r[CTRL_ACK_BIT];
					end
					else
					begin
						sda_oe_n_out <= shift_r[6];
						shift_r      <= {shift_r[6:0], 1'b0};
						bit_r        <= bit_r + 4'd1;
					end
				end
				else if (state_r == S_TX && scl_rise && ack_phase_r)
				begin
					if (sync_r.sda || last_r)
						state_r <= S_WAIT;
				end
				else if (state_r == S_TX && scl_fall && ack_phase_r)
				begin
					ack_phase_r  <= 1'b0;
					shift_r      <= data_r;
					sda_oe_n_out <= data_r[7];
					bit_r        <= 4'd1;
				end
			end
		end
	end

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	low_bits_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
		event_r |-> status_r[2:0] == 3'b000) else $error("status low bits not zero");
	code_with_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ev |=> event_r && status_r == {$past(ev_code[7:3]), 3'b000}) else $error("code and flag out of step");
	idle_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!event_r && !$past(ev) |-> status_r == ST_IDLE) else $error("idle code wrong");
	timeout_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
		tmo_hit |=> status_r == ST_TIMEOUT) else $error("timeout code missing");
	stop_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
		stop_c && state_r == S_RX && bit_r < 4'd2 && !tmo_hit |=> status_r == ST_STOP) else $error("stop code missing");
	rx_ack_a: assert property (@(posedge clk_in) disable iff (rst_in)
		scl_fall && ack_phase_r && state_r == S_RX && !gc_r && ack_out_r && !tmo_hit && !start_c && !stop_c
		|=> status_r == ST_RX_ACK) else $error("rx ack code missing");
	rx_nack_a: assert property (@(posedge clk_in) disable iff (rst_in)
		scl_fall && ack_phase_r && state_r == S_RX && !gc_r && !ack_out_r && !tmo_hit && !start_c && !stop_c
		|=> status_r == ST_RX_NACK) else $error("rx nack code missing");
	tx_nack_a: assert property (@(posedge clk_in) disable iff (rst_in)
		scl_rise && ack_phase_r && state_r == S_TX && sync_r.sda && !tmo_hit && !start_c && !stop_c
		|=> status_r == ST_TX_NACK) else $error("tx nack code missing");
	own_w_c: cover property (@(posedge clk_in) disable iff (rst_in) ev && ev_code == ST_OWN_W);
	own_r_c: cover property (@(posedge clk_in) disable iff (rst_in) ev && ev_code == ST_OWN_R);
	rx_ack_c: cover property (@(posedge clk_in) disable iff (rst_in) ev && ev_code == ST_RX_ACK);
	stop_c_c: cover property (@(posedge clk_in) disable iff (rst_in) ev && ev_code == ST_STOP);
endmodule // smb_status_coder

// ==== bench/smb_master_model.sv ====
// two-wire bus master model that drives scl and shares sda with the device
`timescale 1ns/1ps
module smb_master_model
(
	input  wire logic clk_in,      // system clock for pacing
	input  wire logic sda_oe_n_in, // device pulls sda while low
	output logic      scl_out,     // bus clock level
	output logic      sda_out      // wired sda level with pull-up
);
	logic sda_low;
	assign sda_out = sda_oe_n_in & ~sda_low;
	initial
	begin
		scl_out = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// sda moves one cycle after scl falls so no false start or stop is seen
	task automatic bit_out(input logic b);
		tick(1);
		sda_low <= ~b;
		tick(3);
		scl_out <= 1'b1;
		tick(4);
		scl_out <= 1'b0;
	endtask
	task automatic sample(output logic b);
		tick(1);
		sda_low <= 1'b0;
		tick(3);
		scl_out <= 1'b1;
		tick(2);
		b = sda_out;
		tick(2);
		scl_out <= 1'b0;
	endtask
	task automatic start();
		tick(1);
		sda_low <= 1'b0;
		tick(3);
		scl_out <= 1'b1;
		tick(4);
		sda_low <= 1'b1;
		tick(4);
		scl_out <= 1'b0;
	endtask
	task automatic stop();
		scl_out <= 1'b0;
		tick(1);
		sda_low <= 1'b1;
		tick(3);
		scl_out <= 1'b1;
		tick(4);
		sda_low <= 1'b0;
		tick(4);
	endtask
	// both lines high inside a frame, without a stop
	task automatic float_high();
		tick(1);
		sda_low <= 1'b0;
		tick(3);
		scl_out <= 1'b1;
	endtask
	task automatic write_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_out(b[i]);
		sample(s);
		ack = ~s;
	endtask
	task automatic read_byte(input logic ack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			sample(d[i]);
		bit_out(~ack);
	endtask
endmodule // smb_master_model

// ==== bench/testbench.sv ====
// self-checking bench for the two-wire slave status coder
`timescale 1ns/1ps
module testbench;
	import smb_status_pkg::*;
	logic        clk_in;
	logic        rst_in;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        scl;
	logic        sda;
	logic        sda_oe_n;
	logic [7:0]  ctl;
	int          errors = 0;
	int          checked = 0;
	int          cycles = 0;
	smb_status_coder i_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .scl_in(scl), .sda_in(sda), .sda_oe_n_out(sda_oe_n));
	smb_master_model i_master (.clk_in(clk_in), .sda_oe_n_in(sda_oe_n), .scl_out(scl), .sda_out(sda));
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_in);
		penable <= 1'b1;
		@(posedge clk_in);
		while (pready !== 1'b1)
			@(posedge clk_in);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, a, {24'h0, d}, rd, e);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] rd;
		logic        e;
		apb(1'b0, a, 32'h0, rd, e);
		chk(rd, exp);
		chk({31'h0, e}, {31'h0, exp_err});
	endtask
	task automatic set_ctl(input logic [7:0] c);
		ctl = c;
		wr(CTRL_ADDR, c);
	endtask
	task automatic expect_idle();
		rd_chk(STATUS_ADDR, {24'h0, ST_IDLE}, 1'b0);
		rd_chk(CTRL_ADDR, {24'h0, ctl}, 1'b0);
	endtask
	// flag read first, then the code in a second read, then the flag is cleared
	task automatic expect_code(input logic [7:0] code);
		repeat (8) @(posedge clk_in);
		rd_chk(CTRL_ADDR, {24'h0, ctl | 8'h08}, 1'b0);
		rd_chk(STATUS_ADDR, {24'h0, code}, 1'b0);
		wr(CTRL_ADDR, ctl);
	endtask
	task automatic end_bus();
		wr(CTRL_ADDR, ctl | 8'h10);
		i_master.stop();
		expect_idle();
	endtask
	task automatic send(input logic [7:0] b, input logic exp_ack);
		logic a;
		i_master.write_byte(b, a);
		chk({31'h0, a}, {31'h0, exp_ack});
	endtask
	task automatic addr_own(input logic [7:0] b, input logic [7:0] code);
		i_master.start();
		send(b, 1'b1);
		expect_code(code);
	endtask
	task automatic t_idle();
		expect_idle();
		rd_chk(DATA_ADDR, 32'h0, 1'b0);
		rd_chk(RATE_ADDR, 32'h0, 1'b0);
		rd_chk(8'h14, 32'h0, 1'b1);
		wr(OWNADDR_ADDR, 8'h2A);
		rd_chk(OWNADDR_ADDR, 32'h2A, 1'b0);
	endtask
	task automatic t_write();
		set_ctl(8'h45);
		i_master.start();
		send(8'h30, 1'b0);
		i_master.stop();
		expect_idle();
		addr_own(8'h54, ST_OWN_W);
		send(8'hC3, 1'b1);
		expect_code(ST_RX_ACK);
		rd_chk(DATA_ADDR, 32'hC3, 1'b0);
		i_master.stop();
		expect_code(ST_STOP);
		expect_idle();
		addr_own(8'h54, ST_OWN_W);
		set_ctl(8'h41);
		send(8'h5A, 1'b0);
		expect_code(ST_RX_NACK);
		end_bus();
	endtask
	task automatic t_gc();
		set_ctl(8'h45);
		addr_own(8'h00, ST_GC);
		send(8'h11, 1'b1);
		expect_code(ST_GC_ACK);
		i_master.stop();
		expect_code(ST_STOP);
		addr_own(8'h00, ST_GC);
		set_ctl(8'h41);
		send(8'h22, 1'b0);
		expect_code(ST_GC_NACK);
		end_bus();
	endtask
	task automatic t_read();
		logic [7:0] d;
		set_ctl(8'h45);
		wr(DATA_ADDR, 8'hA5);
		addr_own(8'h55, ST_OWN_R);
		i_master.read_byte(1'b1, d);
		chk({24'h0, d}, 32'hA5);
		expect_code(ST_TX_ACK);
		set_ctl(8'h41);
		i_master.read_byte(1'b1, d);
		expect_code(ST_TX_LAST);
		end_bus();
		set_ctl(8'h45);
		addr_own(8'h55, ST_OWN_R);
		i_master.read_byte(1'b0, d);
		expect_code(ST_TX_NACK);
		end_bus();
	endtask
	task automatic t_lost();
		logic [7:0] adr [3] = '{8'h54, 8'h00, 8'h55};
		logic [7:0] code [3] = '{ST_LOST_OWN_W, ST_LOST_GC, ST_LOST_OWN_R};
		for (int i = 0; i < 3; i++)
		begin
			set_ctl(8'h47);
			addr_own(adr[i], code[i]);
			end_bus();
		end
	endtask
	task automatic t_timeout();
		wr(RATE_ADDR, 8'hFF);
		rd_chk(RATE_ADDR, 32'hFF, 1'b0);
		set_ctl(8'h45);
		addr_own(8'h54, ST_OWN_W);
		i_master.float_high();
		repeat (30) @(posedge clk_in);
		expect_code(ST_TIMEOUT);
		end_bus();
		wr(RATE_ADDR, 8'h00);
	endtask
	task automatic t_bus_error();
		set_ctl(8'h45);
		addr_own(8'h54, ST_OWN_W);
		i_master.bit_out(1'b1);
		i_master.bit_out(1'b0);
		i_master.start();
		expect_code(ST_BUS_ERR);
		end_bus();
	endtask
	initial
	begin
		rst_in = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ctl = 8'h00;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		t_idle();
		t_write();
		t_gc();
		t_read();
		t_lost();
		t_timeout();
		t_bus_error();
		complete_run();
	end
endmodule // testbench
